// >>> core/ccl_pkg.sv
// Constants, register map and carrier types of the control subsystem clock block
package ccl_pkg;
    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] CCL_A_GATE0 = 8'h00;
    localparam logic [7:0] CCL_A_PEREN = 8'h04;
    localparam logic [7:0] CCL_A_T2SEL = 8'h08;
    localparam logic [7:0] CCL_A_T2DIV = 8'h0C;
    localparam logic [7:0] CCL_A_LSP = 8'h10;
    localparam logic [7:0] CCL_A_HSP = 8'h14;
    localparam logic [7:0] CCL_A_ANA = 8'h18;
    localparam logic [7:0] CCL_A_SYSDIV = 8'h1C;
    localparam logic [7:0] CCL_A_PLLREQ = 8'h20;
    localparam logic [7:0] CCL_A_WAKE = 8'h24;
    localparam logic [7:0] CCL_A_NMI = 8'h28;
    localparam logic [7:0] CCL_A_STAT = 8'h2C;
    localparam logic [7:0] CCL_A_HSK = 8'h30;
    // ------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------
    localparam int CCL_LPM_LO = 0;
    localparam int CCL_QUAL_LO = 2;
    localparam int CCL_WK_EN_BIT = 8;
    localparam logic [1:0] CCL_LPM_IDLE = 2'h0;
    localparam logic [1:0] CCL_LPM_STBY = 2'h1;
    localparam logic [1:0] CCL_T2_SYS = 2'h0;
    localparam logic [1:0] CCL_T2_OSC = 2'h1;
    localparam logic [7:0] CCL_GATE0_RST = 8'h00;
    localparam logic [7:0] CCL_DIV_RST = 8'h00;
    localparam logic [7:0] CCL_ANA_RST = 8'h03;
    localparam logic [7:0] CCL_LSP_RST = 8'h02;
    // ------------------------------------------------------------
    // Synchronised pin bundle positions
    // ------------------------------------------------------------
    localparam int CCL_NPIN = 64;
    localparam int CCL_S_DS = 64;
    localparam int CCL_S_IPC = 65;
    localparam int CCL_S_OSC = 66;
    localparam int CCL_S_PLL = 67;
    localparam int CCL_S_BAK = 68;
    localparam int CCL_S_ARB = 69;
    localparam int CCL_S_ARS = 70;
    localparam int CCL_S_RCL = 71;
    localparam int CCL_SW = 72;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CCL_NORMAL = 2'h0,
        CCL_IDLE = 2'h1,
        CCL_STANDBY = 2'h2
    } ccl_mode_e;
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } ccl_apb_req_s;
    typedef struct packed {
        logic pll_sys;
        logic input_clk;
        logic periph;
        logic core;
        logic timer2;
        logic lsp;
        logic hsp;
        logic analog;
        logic shared;
    } ccl_clk_en_s;
endpackage

// >>> core/ccl_clock_lowpower.sv
// Control subsystem clock derivation, gating, low-power sequencing and clock-loss watch
//
// What this block does
// - Control side asks PLL write ownership; master side takes it back.
// - Each peripheral clock runs only when its enable bit is set.
// - Two clocks out: peripheral clock (peripherals, timers) and core clock.
// - Normal: both run; Idle: core stops; Standby: input, core, peripheral stop.
// - Timer 2 clock is divided from peripheral, oscillator or backup clock.
// - Low and high speed prescalers make serial and pulse-stretch clocks.
// - Wait sets halt status; with low-power bits selects Idle or Standby.
// - Idle ends on any enabled interrupt or the control NMI.
// - Leaving Idle restores core clock; optional wake ISR request and resume pulse come in the same cycle.
// - Standby ends on one selected wake pin of 64 or IPC interrupt 1.
// - Wake pin is qualified using count bits 7:2 of gate register 0.
// - Leaving Standby restores all clocks; optional wake ISR request and resume pulse come in the same cycle.
// - Input clock is off while master is in Deep Sleep.
// - Analog clock is PLL system clock divided by the analog divider.
// - Analog divider register resets on either analog reset.
// - Analog clock stops while master is in Deep Sleep.
// - Shared RAMs and IPC use PLL system clock; EPI uses master clock.
// - PLL system clock: PLL or oscillator divided; backup on clock loss.
// - Only the oscillator is watched, by a detector on the backup clock.
// - Clock loss drives both NMIs, PWM trip, mux; NMI watchdogs reset device.
module ccl_clock_lowpower #(
    parameter int NPER = 16,
    parameter int MCD_LIMIT = 8,
    parameter int WD_LIMIT = 65535
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire ccl_pkg::ccl_apb_req_s apb_req,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic [63:0] wake_pins,
    input wire logic master_deep_sleep,
    input wire logic master_to_ctrl_ipc_irq1,
    input wire logic oscillator_clock,
    input wire logic pll_clock,
    input wire logic internal_backup_clock,
    input wire logic pll_bypass,
    input wire logic analog_bus_reset,
    input wire logic analog_soft_reset,
    input wire logic pll_write_reclaim,
    input wire logic master_subsystem_clock,
    input wire logic cpu_wait_exec,
    input wire logic enabled_irq,
    input wire logic ctrl_nonmaskable_irq,
    output ccl_pkg::ccl_clk_en_s clk_en,
    output logic [NPER-1:0] periph_clk_en,
    output logic epi_clk_en,
    output logic halt_status,
    output logic wake_isr_req,
    output logic cpu_resume,
    output logic pll_write_owner,
    output logic [7:0] system_clock_divider,
    output logic [7:0] ctrl_lowpower_handshake,
    output logic source_clock_lost,
    output logic nmi_master,
    output logic nmi_ctrl,
    output logic pwm_trip,
    output logic device_reset_req
);
    import ccl_pkg::*;

    typedef struct packed {
        logic [CCL_SW-1:0] s1;
        logic [CCL_SW-1:0] s2;
        logic [CCL_SW-1:0] s3;
        ccl_mode_e mode;
        logic halt;
        logic wake;
        logic resume;
        logic [7:0] gate0;
        logic [NPER-1:0] per_en;
        logic [1:0] t2sel;
        logic [7:0] t2div;
        logic [7:0] lsp;
        logic [7:0] hsp;
        logic [7:0] ana;
        logic [7:0] sysdiv;
        logic owner;
        logic [8:0] wake_cfg;
        logic [1:0] wd_dis;
        logic [7:0] hsk;
        logic [7:0] c_sys;
        logic [7:0] c_t2;
        logic [7:0] c_lsp;
        logic [7:0] c_hsp;
        logic [7:0] c_ana;
        logic [6:0] qcnt;
        logic [15:0] mcd;
        logic lost;
        logic [1:0][31:0] wd;
        logic rst_req;
        logic [31:0] rdata;
        ccl_clk_en_s ck;
        logic [NPER-1:0] pck;
    } ccl_state_s;

    ccl_state_s s_q, s_d;

    // ------------------------------------------------------------
    // Divider step: ratio is div + 1 ticks per output enable
    // ------------------------------------------------------------
    function automatic logic [8:0] div_step(input logic [7:0] cnt, input logic [7:0] div,
                                            input logic tick);
        logic [8:0] r;
        r = {1'b0, cnt};
        if (tick) begin
            if (cnt >= div) begin
                r = {1'b1, 8'h00};
            end else begin
                r = {1'b0, cnt + 8'h01};
            end
        end
        return r;
    endfunction

    logic ds, ipc, osc_e, pll_e, bak_e, ana_rst, reclaim_e, src_tick, sel_pin;
    logic qualified, wake_std, wake_idle, acc, setup, wr, mapped;
    logic [8:0] r_sys, r_t2, r_lsp, r_hsp, r_ana;
    logic t2_src;

    assign ds = s_q.s2[CCL_S_DS];
    assign ipc = s_q.s2[CCL_S_IPC];
    assign osc_e = s_q.s2[CCL_S_OSC] & ~s_q.s3[CCL_S_OSC];
    assign pll_e = s_q.s2[CCL_S_PLL] & ~s_q.s3[CCL_S_PLL];
    assign bak_e = s_q.s2[CCL_S_BAK] & ~s_q.s3[CCL_S_BAK];
    assign ana_rst = s_q.s2[CCL_S_ARB] | s_q.s2[CCL_S_ARS];
    assign reclaim_e = s_q.s2[CCL_S_RCL] & ~s_q.s3[CCL_S_RCL];
    assign sel_pin = s_q.s2[s_q.wake_cfg[5:0]];
    assign qualified = s_q.qcnt > {1'b0, s_q.gate0[7:CCL_QUAL_LO]};
    assign wake_std = qualified | ipc;
    assign wake_idle = enabled_irq | ctrl_nonmaskable_irq;
    assign setup = apb_req.psel & ~apb_req.penable;
    assign acc = apb_req.psel & apb_req.penable;
    assign wr = acc & apb_req.pwrite & mapped;

    always_comb begin
        unique case (apb_req.paddr)
            CCL_A_GATE0, CCL_A_PEREN, CCL_A_T2SEL, CCL_A_T2DIV, CCL_A_LSP, CCL_A_HSP,
            CCL_A_ANA, CCL_A_SYSDIV, CCL_A_PLLREQ, CCL_A_WAKE, CCL_A_NMI, CCL_A_STAT,
            CCL_A_HSK: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.s1 = {pll_write_reclaim, analog_soft_reset, analog_bus_reset,
                  internal_backup_clock, pll_clock, oscillator_clock,
                  master_to_ctrl_ipc_irq1, master_deep_sleep, wake_pins};
        s_d.s2 = s_q.s1;
        s_d.s3 = s_q.s2;
        s_d.wake = 1'b0;
        s_d.resume = 1'b0;

        // Register writes
        if (wr) begin
            unique case (apb_req.paddr)
                CCL_A_GATE0: s_d.gate0 = apb_req.pwdata[7:0];
                CCL_A_PEREN: s_d.per_en = apb_req.pwdata[NPER-1:0];
                CCL_A_T2SEL: s_d.t2sel = apb_req.pwdata[1:0];
                CCL_A_T2DIV: s_d.t2div = apb_req.pwdata[7:0];
                CCL_A_LSP: s_d.lsp = apb_req.pwdata[7:0];
                CCL_A_HSP: s_d.hsp = apb_req.pwdata[7:0];
                CCL_A_ANA: s_d.ana = apb_req.pwdata[7:0];
                CCL_A_SYSDIV: if (s_q.owner) s_d.sysdiv = apb_req.pwdata[7:0];
                CCL_A_WAKE: s_d.wake_cfg = apb_req.pwdata[8:0];
                CCL_A_NMI: s_d.wd_dis = apb_req.pwdata[1:0];
                CCL_A_HSK: s_d.hsk = apb_req.pwdata[7:0];
                default: s_d.hsk = s_q.hsk;
            endcase
        end
        // Ownership: a request in the same cycle as a reclaim wins
        if (reclaim_e) begin
            s_d.owner = 1'b0;
        end
        if (wr && apb_req.paddr == CCL_A_PLLREQ && apb_req.pwdata[0]) begin
            s_d.owner = 1'b1;
        end
        if (ana_rst) begin
            s_d.ana = CCL_ANA_RST;
        end

        // Wake pin qualification
        if (!sel_pin) begin
            s_d.qcnt = 7'h00;
        end else if (!qualified) begin
            s_d.qcnt = s_q.qcnt + 7'h01;
        end

        // Low-power sequencing
        unique case (s_q.mode)
            CCL_NORMAL: begin
                if (cpu_wait_exec) begin
                    s_d.halt = 1'b1;
                    s_d.mode = (s_q.gate0[CCL_LPM_LO +: 2] == CCL_LPM_STBY) ?
                               CCL_STANDBY : CCL_IDLE;
                end
            end
            CCL_IDLE: begin
                if (wake_idle) begin
                    s_d.mode = CCL_NORMAL;
                    s_d.halt = 1'b0;
                    s_d.wake = s_q.wake_cfg[CCL_WK_EN_BIT];
                    s_d.resume = 1'b1;
                end
            end
            CCL_STANDBY: begin
                if (wake_std) begin
                    s_d.mode = CCL_NORMAL;
                    s_d.halt = 1'b0;
                    s_d.wake = s_q.wake_cfg[CCL_WK_EN_BIT];
                    s_d.resume = 1'b1;
                end
            end
            default: s_d.mode = CCL_NORMAL;
        endcase

        // Missing clock detector, counted on backup clock edges
        if (osc_e) begin
            s_d.mcd = 16'h0000;
        end else if (bak_e && !s_q.lost) begin
            s_d.mcd = s_q.mcd + 16'h0001;
        end
        if (s_q.mcd >= 16'(MCD_LIMIT)) begin
            s_d.lost = 1'b1;
        end
        for (int i = 0; i < 2; i++) begin
            if (s_q.lost && !s_q.wd_dis[i]) begin
                if (s_q.wd[i] >= 32'(WD_LIMIT)) begin
                    s_d.rst_req = 1'b1;
                end else begin
                    s_d.wd[i] = s_q.wd[i] + 32'h00000001;
                end
            end
        end

        // Clock enables
        src_tick = s_q.lost ? bak_e : (pll_bypass ? osc_e : pll_e);
        r_sys = div_step(s_q.c_sys, s_q.sysdiv, src_tick);
        s_d.c_sys = r_sys[7:0];
        s_d.ck.pll_sys = r_sys[8];
        s_d.ck.input_clk = r_sys[8] & ~ds & (s_q.mode != CCL_STANDBY);
        s_d.ck.shared = r_sys[8] & ~ds;
        s_d.ck.periph = s_d.ck.input_clk & (s_q.mode != CCL_STANDBY);
        s_d.ck.core = s_d.ck.input_clk & (s_q.mode == CCL_NORMAL);
        s_d.pck = {NPER{s_d.ck.periph}} & s_q.per_en;
        unique case (s_q.t2sel)
            CCL_T2_SYS: t2_src = s_d.ck.periph;
            CCL_T2_OSC: t2_src = osc_e & ~ds;
            default: t2_src = bak_e & ~ds;
        endcase
        r_t2 = div_step(s_q.c_t2, s_q.t2div, t2_src);
        r_lsp = div_step(s_q.c_lsp, s_q.lsp, s_d.ck.periph);
        r_hsp = div_step(s_q.c_hsp, s_q.hsp, s_d.ck.periph);
        r_ana = div_step(s_q.c_ana, s_q.ana, r_sys[8]);
        s_d.c_t2 = r_t2[7:0];
        s_d.c_lsp = r_lsp[7:0];
        s_d.c_hsp = r_hsp[7:0];
        s_d.c_ana = ana_rst ? 8'h00 : r_ana[7:0];
        s_d.ck.timer2 = r_t2[8];
        s_d.ck.lsp = r_lsp[8];
        s_d.ck.hsp = r_hsp[8];
        s_d.ck.analog = r_ana[8] & ~ds;

        // Read data is captured in the setup phase
        if (setup) begin
            unique case (apb_req.paddr)
                CCL_A_GATE0: s_d.rdata = {24'h000000, s_q.gate0};
                CCL_A_PEREN: s_d.rdata = 32'(s_q.per_en);
                CCL_A_T2SEL: s_d.rdata = {30'h00000000, s_q.t2sel};
                CCL_A_T2DIV: s_d.rdata = {24'h000000, s_q.t2div};
                CCL_A_LSP: s_d.rdata = {24'h000000, s_q.lsp};
                CCL_A_HSP: s_d.rdata = {24'h000000, s_q.hsp};
                CCL_A_ANA: s_d.rdata = {24'h000000, s_q.ana};
                CCL_A_SYSDIV: s_d.rdata = {24'h000000, s_q.sysdiv};
                CCL_A_PLLREQ: s_d.rdata = {31'h00000000, s_q.owner};
                CCL_A_WAKE: s_d.rdata = {23'h000000, s_q.wake_cfg};
                CCL_A_NMI: s_d.rdata = {30'h00000000, s_q.wd_dis};
                CCL_A_STAT: s_d.rdata = {24'h000000, qualified, ds, s_q.rst_req,
                                         s_q.lost, s_q.owner, s_q.halt, s_q.mode};
                CCL_A_HSK: s_d.rdata = {24'h000000, s_q.hsk};
                default: s_d.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
            s_q.gate0 <= CCL_GATE0_RST;
            s_q.ana <= CCL_ANA_RST;
            s_q.lsp <= CCL_LSP_RST;
            s_q.sysdiv <= CCL_DIV_RST;
            s_q.mode <= CCL_NORMAL;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign pready = acc;
    assign pslverr = acc & ~mapped;
    assign prdata = s_q.rdata;
    assign clk_en = s_q.ck;
    assign periph_clk_en = s_q.pck;
    assign epi_clk_en = master_subsystem_clock;
    assign halt_status = s_q.halt;
    assign wake_isr_req = s_q.wake;
    assign cpu_resume = s_q.resume;
    assign pll_write_owner = s_q.owner;
    assign system_clock_divider = s_q.sysdiv;
    assign ctrl_lowpower_handshake = s_q.hsk;
    assign source_clock_lost = s_q.lost;
    assign nmi_master = s_q.lost;
    assign nmi_ctrl = s_q.lost;
    assign pwm_trip = s_q.lost;
    assign device_reset_req = s_q.rst_req;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_core_normal_only: assert property (s_q.ck.core |-> $past(s_q.mode) == CCL_NORMAL)
        else $error("core clock ran outside normal mode");
    a_periph_gate_en: assert property ((s_q.pck & ~$past(s_q.per_en)) == '0)
        else $error("disabled peripheral got a clock");
    a_standby_stops: assert property ($past(s_q.mode) == CCL_STANDBY |->
        !s_q.ck.periph && !s_q.ck.core && !s_q.ck.input_clk)
        else $error("clock ran in standby");
    a_wait_enters_lp: assert property (s_q.mode == CCL_NORMAL && cpu_wait_exec |=>
        s_q.halt && s_q.mode != CCL_NORMAL)
        else $error("wait did not enter low power");
    a_idle_exit: assert property (s_q.mode == CCL_IDLE && wake_idle |=>
        s_q.mode == CCL_NORMAL && s_q.resume)
        else $error("idle not left on interrupt");
    a_standby_exit: assert property (s_q.mode == CCL_STANDBY && ipc |=>
        s_q.mode == CCL_NORMAL)
        else $error("standby not left on ipc interrupt");
    a_resume_pulse: assert property (s_q.resume |-> $past(s_q.mode) != CCL_NORMAL
        ##1 !s_q.resume)
        else $error("resume pulse misplaced");
    a_input_off_ds: assert property ($past(ds) |-> !s_q.ck.input_clk && !s_q.ck.analog)
        else $error("clock ran in deep sleep");
    a_lost_sticky: assert property (s_q.lost |=> s_q.lost && nmi_ctrl)
        else $error("clock loss flag dropped");
    a_owner_request: assert property (wr && apb_req.paddr == CCL_A_PLLREQ &&
        apb_req.pwdata[0] |=> s_q.owner)
        else $error("ownership request ignored");
    a_analog_reset: assert property (ana_rst |=> s_q.ana == CCL_ANA_RST)
        else $error("analog divider not reset");

    c_idle_trip: cover property (s_q.mode == CCL_IDLE ##[1:50] s_q.resume);
    c_standby_trip: cover property (s_q.mode == CCL_STANDBY ##[1:200] s_q.resume);
    c_clock_lost: cover property ($rose(s_q.lost));
endmodule

// >>> test/ccl_master_model.sv
// Master side stand-in: source clocks, deep sleep entry and wake handshake
module ccl_master_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic sleep_cmd,
    input wire logic osc_stop,
    input wire logic ctrl_halt,
    input wire logic [7:0] handshake,
    output logic deep_sleep,
    output logic ipc_irq1,
    output logic osc_clk,
    output logic pll_clk,
    output logic bak_clk
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_q;
    assign bak_clk = cnt_q[3];
    assign osc_clk = cnt_q[2] & ~osc_stop;
    assign pll_clk = cnt_q[2] & ~deep_sleep;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 4'h0;
            deep_sleep <= 1'b0;
            ipc_irq1 <= 1'b0;
        end else begin
            cnt_q <= cnt_q + 4'h1;
            // Sleep only once the control side is halted with a nonzero handshake
            deep_sleep <= sleep_cmd & (deep_sleep | (ctrl_halt & (|handshake)));
            // Wake the halted control side in the same cycle deep sleep ends
            ipc_irq1 <= ctrl_halt & (ipc_irq1 | (deep_sleep & ~sleep_cmd));
        end
    end
endmodule

// >>> test/tb_top.sv
// Self-checking bench for the control subsystem clock block
module tb_top;
    import ccl_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    ccl_apb_req_s req = '0;
    logic [31:0] prdata;
    logic [63:0] pins = '0;
    logic [1:0] arst = '0;
    logic wexec = 1'b0, irq = 1'b0, nmi = 1'b0, recl = 1'b0, sleep = 1'b0, ostop = 1'b0;
    logic pready, pslverr, halt, ds, ipc, osc, pll, bak, owner, lost, nm, nc, trip, rreq;
    logic resume, isr;
    logic byp = 1'b0, msc = 1'b0, epi;
    logic [7:0] hsk, sdiv;
    logic [15:0] pen;
    logic [12:0] ev;
    ccl_clk_en_s ce;
    int fail_count = 0, checks_done = 0, cyc = 0;
    int cnt[13], d[13];
    ccl_clock_lowpower #(.MCD_LIMIT(2), .WD_LIMIT(20)) u_dut (
        .pclk(pclk), .presetn(presetn), .apb_req(req), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .wake_pins(pins), .master_deep_sleep(ds),
        .master_to_ctrl_ipc_irq1(ipc), .oscillator_clock(osc), .pll_clock(pll),
        .internal_backup_clock(bak), .pll_bypass(byp), .analog_bus_reset(arst[0]),
        .analog_soft_reset(arst[1]), .pll_write_reclaim(recl), .master_subsystem_clock(msc),
        .cpu_wait_exec(wexec), .enabled_irq(irq), .ctrl_nonmaskable_irq(nmi), .clk_en(ce),
        .periph_clk_en(pen), .epi_clk_en(epi), .halt_status(halt), .wake_isr_req(isr),
        .cpu_resume(resume), .pll_write_owner(owner), .system_clock_divider(sdiv),
        .ctrl_lowpower_handshake(hsk), .source_clock_lost(lost), .nmi_master(nm),
        .nmi_ctrl(nc), .pwm_trip(trip), .device_reset_req(rreq));
    ccl_master_model u_master (.pclk(pclk), .presetn(presetn), .sleep_cmd(sleep),
        .osc_stop(ostop), .ctrl_halt(halt), .handshake(hsk), .deep_sleep(ds),
        .ipc_irq1(ipc), .osc_clk(osc), .pll_clk(pll), .bak_clk(bak));
    // ----------------------------------------
    // Clock, event counters, timeout
    // ----------------------------------------
    assign ev = {ce.shared, ce.hsp, ce.lsp, ce.timer2, isr, resume, pen[1], pen[0], ce.pll_sys,
                 ce.analog, ce.input_clk, ce.periph, ce.core};
    initial begin
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        for (int i = 0; i < 13; i++) cnt[i] <= cnt[i] + int'(ev[i] === 1'b1);
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            give_verdict();
        end
    end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
        req.psel <= 1'b1;
        req.pwrite <= w;
        req.paddr <= a;
        req.pwdata <= wd;
        @(posedge pclk);
        req.penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        er = pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, v, r, e);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, x);
    endtask
    task automatic span(input int n);
        int s[13];
        s = cnt;
        repeat (n) @(posedge pclk);
        for (int i = 0; i < 13; i++) d[i] = cnt[i] - s[i];
    endtask
    task automatic waitins();
        wexec <= 1'b1;
        @(posedge pclk);
        wexec <= 1'b0;
        @(posedge pclk);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs();
        logic [31:0] r;
        logic e;
        rdc(CCL_A_GATE0, 32'h0);
        rdc(CCL_A_ANA, 32'h3);
        rdc(CCL_A_LSP, 32'h2);
        apb(1'b0, 8'h3C, 32'h0, r, e);
        chk(e, 1'b1);
        wr(CCL_A_SYSDIV, 32'h5);
        rdc(CCL_A_SYSDIV, 32'h0);
        wr(CCL_A_PLLREQ, 32'h1);
        wr(CCL_A_SYSDIV, 32'h5);
        rdc(CCL_A_SYSDIV, 32'h5);
        chk(sdiv, 8'h05);
        wr(CCL_A_SYSDIV, 32'h0);
        recl <= 1'b1;
        repeat (2) @(posedge pclk);
        recl <= 1'b0;
        repeat (5) @(posedge pclk);
        chk(owner, 1'b0);
        $display("test regs done");
    endtask
    task automatic t_gate();
        wr(CCL_A_PEREN, 32'h1);
        span(64);
        chk(d[5], d[1]);
        chk(d[6], 0);
        chk(d[1] > 0 && d[0] > 0, 1);
        chk(d[9], d[1]);
        chk(d[11], d[1]);
        chk(d[10] inside {[2:3]}, 1);
        chk(d[12], d[4]);
        wr(CCL_A_T2SEL, 32'h2);
        span(64);
        chk(d[9] inside {[3:5]}, 1);
        wr(CCL_A_T2SEL, 32'h0);
        msc <= 1'b1;
        @(posedge pclk);
        chk(epi, 1'b1);
        msc <= 1'b0;
        $display("test gate done");
    endtask
    task automatic t_idle();
        wr(CCL_A_WAKE, 32'h100);
        for (int k = 0; k < 2; k++) begin
            waitins();
            repeat (2) @(posedge pclk);
            chk(halt, 1'b1);
            span(32);
            chk(d[0] == 0 && d[1] > 0, 1);
            {nmi, irq} <= 2'b01 << k;
            span(6);
            chk(d[7] + d[8], 2);
            chk(halt, 1'b0);
            {nmi, irq} <= 2'b00;
        end
        $display("test idle done");
    endtask
    task automatic t_stby();
        wr(CCL_A_GATE0, 32'h1);
        wr(CCL_A_HSK, 32'h1);
        waitins();
        sleep <= 1'b1;
        repeat (8) @(posedge pclk);
        span(60);
        chk(d[0] + d[1] + d[2] + d[3], 0);
        chk({ds, lost}, 2'b10);
        chk(d[4], 0);
        byp <= 1'b1;
        span(32);
        chk(d[4] > 0, 1);
        byp <= 1'b0;
        sleep <= 1'b0;
        span(10);
        chk(d[7] + d[8], 2);
        chk(halt, 1'b0);
        $display("test standby done");
    endtask
    task automatic t_pin();
        wr(CCL_A_GATE0, 32'h0D);
        wr(CCL_A_WAKE, 32'h05);
        waitins();
        repeat (4) @(posedge pclk);
        pins[5] <= 1'b1;
        repeat (3) @(posedge pclk);
        pins[5] <= 1'b0;
        span(20);
        chk(d[7], 0);
        chk(halt, 1'b1);
        pins[5] <= 1'b1;
        span(12);
        chk(d[7], 1);
        chk(d[8], 0);
        pins[5] <= 1'b0;
        $display("test pin done");
    endtask
    task automatic t_ana();
        span(400);
        chk(d[4] inside {[49:51]}, 1);
        chk(d[3] * 4 >= d[4] - 4 && d[3] * 4 <= d[4] + 4, 1);
        for (int i = 0; i < 2; i++) begin
            wr(CCL_A_ANA, 32'h7);
            rdc(CCL_A_ANA, 32'h7);
            arst[i] <= 1'b1;
            repeat (3) @(posedge pclk);
            arst <= 2'b00;
            repeat (4) @(posedge pclk);
            rdc(CCL_A_ANA, 32'h3);
        end
        $display("test analog done");
    endtask
    task automatic t_loss();
        wr(CCL_A_NMI, 32'h1);
        ostop <= 1'b1;
        span(200);
        chk({lost, nm, nc, trip}, 4'hF);
        chk(rreq, 1'b1);
        chk(d[4] > 0, 1);
        $display("test loss done");
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_gate();
        t_idle();
        t_stby();
        t_pin();
        t_ana();
        t_loss();
        give_verdict();
    end
endmodule
